/* design/viu_pkg.sv */
package viu_pkg;

    // ------------------------------------------------------------
    // Source numbering, vector table
    // ------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam logic [2:0] SRC_PIN32 = 3'h0;
    localparam logic [2:0] SRC_PIN33 = 3'h1;
    localparam logic [2:0] SRC_PIN31 = 3'h2;
    localparam logic [2:0] SRC_WIDE_TMR = 3'h3;
    localparam logic [2:0] SRC_NARROW_TMR = 3'h4;
    localparam logic [2:0] SRC_LOW_VOLT = 3'h5;
    localparam logic [15:0] VECTOR_BASE = 16'h0000;
    localparam logic [15:0] VECTOR_TABLE_BYTES = 16'h000c;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_REQ_EDGE = 10'h0fa;
    localparam logic [9:0] IDX_REQ_ENABLE = 10'h0fb;
    localparam logic [9:0] IDX_PRIORITY = 10'h0f9;
    localparam logic [9:0] IDX_PIN_LEVEL = 10'h0f0;
    localparam logic [9:0] IDX_CONTROL = 10'h0f1;
    localparam logic [9:0] IDX_LAST_VECTOR = 10'h0f2;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h0f3;
    localparam logic [9:0] IDX_EVT_MASK = 10'h0f4;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int REQ_EDGE31_BIT = 7;
    localparam int REQ_EDGE32_BIT = 6;
    localparam int ENA_GLOBAL_BIT = 7;
    localparam int CTL_ANALOG_BIT = 0;
    localparam int CTL_CNT_IE_BIT = 1;
    localparam int CTL_CAP_IE_BIT = 2;
    localparam int CTL_TIN_SEL_BIT = 3;
    localparam int EVT_SERVED_BIT = 0;
    localparam int EVT_OVERRUN_BIT = 1;
    localparam logic [7:0] REQ_EDGE_RST = 8'h00;
    localparam logic [7:0] REQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] PRIORITY_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [1:0] EVT_RST = 2'h0;

    // ------------------------------------------------------------
    // Interrupt machine cycle states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAVE_PC = 3'b001,
        ST_SAVE_FLAGS = 3'b010,
        ST_FETCH_HI = 3'b011,
        ST_WAIT_HI = 3'b100,
        ST_FETCH_LO = 3'b101,
        ST_WAIT_LO = 3'b110,
        ST_LOAD_PC = 3'b111
    } viu_state_t;

    // Edge hit for a pin request: rising, falling or both
    function automatic logic viu_edge_hit(input logic rise, input logic fall,
                                          input logic sel_rise, input logic sel_both);
        viu_edge_hit = sel_both ? (rise | fall) : (sel_rise ? rise : fall);
    endfunction : viu_edge_hit

    // Even byte of the vector pair for a source
    function automatic logic [15:0] viu_vector_addr(input logic [2:0] src);
        viu_vector_addr = VECTOR_BASE + {12'h000, src, 1'b0};
    endfunction : viu_vector_addr

endpackage : viu_pkg

/* design/viu_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
module viu_edge_det
    import viu_pkg::*;
(
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic async_in, // Pin or comparator level
    output logic level, // Synchronised level
    output logic rise, // One-cycle rising edge pulse
    output logic fall // One-cycle falling edge pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ------------------------------------------------------------
    // Two-stage synchroniser, then edge compare on the second stage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule : viu_edge_det
`default_nettype wire

/* design/viu_prio_enc.sv */
`timescale 1ns/1ps
`default_nettype none
module viu_prio_enc
    import viu_pkg::*;
(
    input wire logic [5:0] req, // Pending and enabled requests
    input wire logic [2:0] first, // Source that ranks highest
    output logic valid, // Some request present
    output logic [2:0] winner // Chosen source
);
    // Rotating order: first, first+1, ... wrapping after source 5
    always_comb begin
        logic [2:0] idx;
        idx = 3'h0;
        valid = 1'b0;
        winner = 3'h0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            idx = 3'((int'(first) + k) % NUM_SRC);
            if (req[idx]) begin
                valid = 1'b1;
                winner = idx;
            end
        end
    end
endmodule : viu_prio_enc
`default_nettype wire

/* design/viu_top.sv */
//
// Overview of operation
// R01: Six vector pairs 0,1 to 10,11: pins 3.2, 3.3, 3.1 or timer in, two timers, low voltage.
// R02: The pin 3.3 request fires only on a falling edge of that pin.
// R03: A priority encoder set by the priority register picks among several pending requests.
// R04: A grant starts a machine cycle that drops the global enable and saves PC and flags first.
// R05: The cycle reads the vector byte and the next as a 16-bit address and loads it into the PC.
// R06: Masked requests are still latched in the request register so software can poll them.
// R07: Comparator 1 feeds the pin 3.1 request, comparator 2 the pin 3.2 request.
// R08: Pin 3.1 and pin 3.2 requests trigger on rising, falling or both edges.
// R09: Request register bits 7 and 6 choose the edges: 00 F/F, 01 F/R, 10 R/F, 11 both/both.
// R10: Software reads the live pin levels apart from the latched requests.
// R11: The lowest twelve program bytes hold the six 16-bit vectors.
// R12: Narrow timer timeout needs its counter enable, capture needs its capture enable.
// R13: A grant clears that source's pending bit so each event is served once.
//
`timescale 1ns/1ps
`default_nettype none
module viu_top
    import viu_pkg::*;
(
    input wire logic sys_clk, // Core clock, 200 MHz
    input wire logic rst_n, // Synchronous reset, active low
    // APB slave
    input wire logic psel, // Slave select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write when high
    input wire logic [11:0] paddr, // Byte address
    input wire logic [31:0] pwdata, // Write data
    output logic [31:0] prdata, // Read data
    output logic pready, // Transfer done
    output logic pslverr, // Unmapped address
    // Request sources
    input wire logic port3_bit1_pin, // Pin 3.1 level
    input wire logic port3_bit2_pin, // Pin 3.2 level
    input wire logic port3_bit3_pin, // Pin 3.3 level
    input wire logic timer_input_pin, // Timer input pin level
    input wire logic first_comparator_out, // Comparator 1 output
    input wire logic second_comparator_out, // Comparator 2 output
    input wire logic wide_timer_event, // Wide timer count pulse
    input wire logic narrow_timer_timeout, // Narrow timer timeout pulse
    input wire logic narrow_timer_capture, // Narrow timer capture pulse
    input wire logic low_voltage_detector, // Low voltage level
    // Processor core
    output logic core_int_req, // Interrupt wanted
    input wire logic core_int_ack, // Core at instruction boundary
    input wire logic core_int_return, // Handler done, re-enables
    output logic core_save_pc, // Push program counter
    output logic core_save_flags, // Push status flags
    output logic pmem_rd, // Program memory read strobe
    output logic [15:0] pmem_addr, // Program memory address
    input wire logic [7:0] pmem_rdata, // Data one cycle after strobe
    output logic core_load_pc, // Load handler address
    output logic [15:0] core_handler_addr, // Handler address
    output logic irq // Block event interrupt, level
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] req_edge_r;
    logic [5:0] pending_r;
    logic [5:0] pending_nxt;
    logic [7:0] req_enable_r;
    logic [7:0] priority_r;
    logic [7:0] control_r;
    logic [1:0] evt_status_r;
    logic [1:0] evt_status_nxt;
    logic [1:0] evt_mask_r;
    logic [15:0] last_vector_r;
    logic [2:0] served_src_r;
    logic [15:0] handler_r;
    logic [15:0] pmem_addr_r;
    logic [31:0] prdata_r;
    viu_state_t state_r;
    viu_state_t state_nxt;

    logic lvl31, rise31, fall31;
    logic lvl32, rise32, fall32;
    logic lvl33, rise33, fall33;
    logic lvl_tin, rise_tin, fall_tin;
    logic lvl_an1, rise_an1, fall_an1;
    logic lvl_an2, rise_an2, fall_an2;
    logic lvl_lvd, rise_lvd, fall_lvd;

    // ------------------------------------------------------------
    // Input synchronisers and edge detectors
    // ------------------------------------------------------------
    viu_edge_det u_p31 (.sys_clk, .rst_n, .async_in(port3_bit1_pin),
                        .level(lvl31), .rise(rise31), .fall(fall31));
    viu_edge_det u_p32 (.sys_clk, .rst_n, .async_in(port3_bit2_pin),
                        .level(lvl32), .rise(rise32), .fall(fall32));
    viu_edge_det u_p33 (.sys_clk, .rst_n, .async_in(port3_bit3_pin),
                        .level(lvl33), .rise(rise33), .fall(fall33));
    viu_edge_det u_tin (.sys_clk, .rst_n, .async_in(timer_input_pin),
                        .level(lvl_tin), .rise(rise_tin), .fall(fall_tin));
    viu_edge_det u_an1 (.sys_clk, .rst_n, .async_in(first_comparator_out),
                        .level(lvl_an1), .rise(rise_an1), .fall(fall_an1));
    viu_edge_det u_an2 (.sys_clk, .rst_n, .async_in(second_comparator_out),
                        .level(lvl_an2), .rise(rise_an2), .fall(fall_an2));
    viu_edge_det u_lvd (.sys_clk, .rst_n, .async_in(low_voltage_detector),
                        .level(lvl_lvd), .rise(rise_lvd), .fall(fall_lvd));

    // ------------------------------------------------------------
    // Source selection and edge choice
    // ------------------------------------------------------------
    wire analog_mode = control_r[CTL_ANALOG_BIT];
    wire tin_sel = control_r[CTL_TIN_SEL_BIT];
    wire both_sel = req_edge_r[REQ_EDGE31_BIT] & req_edge_r[REQ_EDGE32_BIT]; // see R09
    wire rise31_sel = req_edge_r[REQ_EDGE31_BIT]; // see R09
    wire rise32_sel = req_edge_r[REQ_EDGE32_BIT]; // see R09

    // Comparators replace the pins in analog mode
    wire src31_rise = analog_mode ? rise_an1 : (tin_sel ? rise_tin : rise31); // see R07
    wire src31_fall = analog_mode ? fall_an1 : (tin_sel ? fall_tin : fall31); // see R07
    wire src32_rise = analog_mode ? rise_an2 : rise32; // see R07
    wire src32_fall = analog_mode ? fall_an2 : fall32; // see R07

    wire hit_pin31 = viu_edge_hit(src31_rise, src31_fall, rise31_sel, both_sel); // see R08
    wire hit_pin32 = viu_edge_hit(src32_rise, src32_fall, rise32_sel, both_sel); // see R08
    wire hit_pin33 = fall33; // see R02
    wire hit_narrow = (narrow_timer_timeout & control_r[CTL_CNT_IE_BIT])
                    | (narrow_timer_capture & control_r[CTL_CAP_IE_BIT]); // see R12
    // Low voltage is a level; only its onset raises a request
    wire hit_lvd = rise_lvd;

    wire [5:0] src_hit = {hit_lvd, hit_narrow, wide_timer_event,
                          hit_pin31, hit_pin33, hit_pin32}; // see R01

    // ------------------------------------------------------------
    // Priority and grant
    // ------------------------------------------------------------
    wire global_en = req_enable_r[ENA_GLOBAL_BIT];
    wire [5:0] eligible = pending_r & req_enable_r[5:0];
    wire arb_valid;
    wire [2:0] arb_src;

    viu_prio_enc u_prio (
        .req(eligible),
        .first(priority_r[2:0]),
        .valid(arb_valid),
        .winner(arb_src)
    ); // see R03

    // Masked sources still pend, which is what polling relies on
    wire idle = (state_r == ST_IDLE);
    wire grant = idle & global_en & arb_valid & core_int_ack; // see R04
    wire [5:0] grant_clr = grant ? (6'h01 << arb_src) : 6'h00; // see R13

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [9:0] idx = paddr[11:2];
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_req = idx == IDX_REQ_EDGE;
    wire hit_ena = idx == IDX_REQ_ENABLE;
    wire hit_pri = idx == IDX_PRIORITY;
    wire hit_lvl = idx == IDX_PIN_LEVEL;
    wire hit_ctl = idx == IDX_CONTROL;
    wire hit_vec = idx == IDX_LAST_VECTOR;
    wire hit_evs = idx == IDX_EVT_STATUS;
    wire hit_evm = idx == IDX_EVT_MASK;
    wire mapped = hit_req | hit_ena | hit_pri | hit_lvl | hit_ctl | hit_vec | hit_evs | hit_evm;
    wire wr = access & pwrite & mapped;
    wire wr_req = wr & hit_req;
    wire wr_ena = wr & hit_ena;
    wire wr_pri = wr & hit_pri;
    wire wr_ctl = wr & hit_ctl;
    wire wr_evs = wr & hit_evs;
    wire wr_evm = wr & hit_evm;

    // Pin levels read live, apart from the latched requests
    wire [7:0] pin_level = {1'b0, lvl_lvd, lvl_an2, lvl_an1, lvl_tin,
                            lvl33, lvl32, lvl31}; // see R10

    wire [31:0] rd_mux =
        hit_req ? {24'h0, req_edge_r[7:6], pending_r} : // see R06
        hit_ena ? {24'h0, req_enable_r} :
        hit_pri ? {24'h0, priority_r} :
        hit_lvl ? {24'h0, pin_level} :
        hit_ctl ? {24'h0, control_r} :
        hit_vec ? {13'h0, served_src_r, last_vector_r} :
        hit_evs ? {30'h0, evt_status_r} :
        hit_evm ? {30'h0, evt_mask_r} :
        32'h0;

    // Zero wait states: read data is caught in setup, held in access
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0;
        end else if (setup & ~pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Request register: edge select and pending bits
    // ------------------------------------------------------------
    // Writing one clears a pending bit; a new edge in that cycle wins
    always_comb begin
        pending_nxt = pending_r & ~grant_clr; // see R13
        if (wr_req) begin
            pending_nxt = pending_nxt & ~pwdata[5:0];
        end
        pending_nxt = pending_nxt | src_hit; // see R06
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            req_edge_r <= REQ_EDGE_RST;
            pending_r <= 6'h00;
        end else begin
            pending_r <= pending_nxt;
            if (wr_req) begin
                req_edge_r <= {pwdata[7:6], 6'h00}; // see R09
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            priority_r <= PRIORITY_RST;
            control_r <= CONTROL_RST;
            evt_mask_r <= 2'h0;
        end else begin
            if (wr_pri) begin
                priority_r <= {5'h00, pwdata[2:0]};
            end
            if (wr_ctl) begin
                control_r <= {4'h0, pwdata[3:0]};
            end
            if (wr_evm) begin
                evt_mask_r <= pwdata[1:0];
            end
        end
    end

    // Global enable: dropped by the machine cycle, back on return
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            req_enable_r <= REQ_ENABLE_RST;
        end else if (grant) begin
            req_enable_r[ENA_GLOBAL_BIT] <= 1'b0; // see R04
        end else if (wr_ena) begin
            req_enable_r <= {pwdata[7], 1'b0, pwdata[5:0]};
        end else if (core_int_return) begin
            req_enable_r[ENA_GLOBAL_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt machine cycle
    // ------------------------------------------------------------
    always_comb begin
        case (state_r)
            ST_IDLE: begin
                state_nxt = grant ? ST_SAVE_PC : ST_IDLE;
            end
            ST_SAVE_PC: begin
                state_nxt = ST_SAVE_FLAGS;
            end
            ST_SAVE_FLAGS: begin
                state_nxt = ST_FETCH_HI;
            end
            ST_FETCH_HI: begin
                state_nxt = ST_WAIT_HI;
            end
            ST_WAIT_HI: begin
                state_nxt = ST_FETCH_LO;
            end
            ST_FETCH_LO: begin
                state_nxt = ST_WAIT_LO;
            end
            ST_WAIT_LO: begin
                state_nxt = ST_LOAD_PC;
            end
            ST_LOAD_PC: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            served_src_r <= 3'h0;
            pmem_addr_r <= VECTOR_BASE;
            handler_r <= 16'h0;
            last_vector_r <= 16'h0;
        end else begin
            state_r <= state_nxt;
            if (grant) begin
                served_src_r <= arb_src;
            end
            if (state_r == ST_SAVE_FLAGS) begin
                pmem_addr_r <= viu_vector_addr(served_src_r); // see R01
            end
            if (state_r == ST_WAIT_HI) begin
                handler_r[15:8] <= pmem_rdata; // see R05
                pmem_addr_r <= pmem_addr_r + 16'h0001; // see R05
            end
            if (state_r == ST_WAIT_LO) begin
                handler_r[7:0] <= pmem_rdata; // see R05
            end
            if (state_r == ST_LOAD_PC) begin
                last_vector_r <= handler_r;
            end
        end
    end

    // Saves come before any vector fetch, so no handler code can run first
    assign core_save_pc = (state_r == ST_SAVE_PC); // see R04
    assign core_save_flags = (state_r == ST_SAVE_FLAGS); // see R04
    assign pmem_rd = (state_r == ST_FETCH_HI) | (state_r == ST_FETCH_LO); // see R11
    assign pmem_addr = pmem_addr_r;
    assign core_load_pc = (state_r == ST_LOAD_PC); // see R05
    assign core_handler_addr = handler_r;
    assign core_int_req = idle & global_en & arb_valid;

    // ------------------------------------------------------------
    // Block events: served and overrun
    // ------------------------------------------------------------
    // Overrun: an edge arrives for a source that is already pending and is not granted in that cycle
    wire [1:0] evt_set = {|(src_hit & pending_r & ~grant_clr), core_load_pc};

    always_comb begin
        evt_status_nxt = evt_status_r;
        if (wr_evs) begin
            evt_status_nxt = evt_status_nxt & ~pwdata[1:0];
        end
        evt_status_nxt = evt_status_nxt | evt_set;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_status_r <= EVT_RST;
        end else begin
            evt_status_r <= evt_status_nxt;
        end
    end

    assign irq = |(evt_status_r & evt_mask_r);

endmodule : viu_top
`default_nettype wire

/* bench/viu_props.sv */
`timescale 1ns/1ps
`default_nettype none
module viu_props (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic core_int_req, // Request to core
    input wire logic core_int_ack, // Core boundary
    input wire logic core_int_return, // Handler done
    input wire logic core_save_pc, // Push PC
    input wire logic core_save_flags, // Push flags
    input wire logic pmem_rd, // Vector fetch
    input wire logic [15:0] pmem_addr, // Fetch address
    input wire logic [7:0] pmem_rdata, // Fetched byte
    input wire logic core_load_pc, // Load handler
    input wire logic [15:0] core_handler_addr // Handler address
);
// ----------------------------------------
// Machine cycle checks
// ----------------------------------------
default clocking @(posedge sys_clk);
endclocking
default disable iff (!rst_n);
a_grant_saves_pc: assert property (core_int_req && core_int_ack |=> core_save_pc)
    else $error("grant without context save");
a_save_has_grant: assert property (core_save_pc |-> $past(core_int_req && core_int_ack))
    else $error("context save without grant");
a_flags_then_fetch: assert property (core_save_pc |=> core_save_flags ##1
    (pmem_rd && !pmem_addr[0] && pmem_addr < 16'h000c)) else $error("bad vector fetch start");
a_vector_pair: assert property (pmem_rd && !pmem_addr[0] |=> !pmem_rd ##1
    (pmem_rd && pmem_addr == $past(pmem_addr, 2) + 16'h0001)) else $error("second byte wrong");
a_load_after_lo: assert property (pmem_rd && pmem_addr[0] |-> ##2 core_load_pc)
    else $error("handler not loaded");
a_handler_bytes: assert property (core_load_pc |->
    core_handler_addr == {$past(pmem_rdata, 3), $past(pmem_rdata)}) else $error("handler mismatch");
a_int_off_cycle: assert property (core_save_pc |-> !core_int_req [*7])
    else $error("request during machine cycle");
a_off_until_ret: assert property (core_load_pc && !core_int_return |=> !core_int_req)
    else $error("request before return");
endmodule : viu_props
bind viu_top viu_props i_props (.sys_clk, .rst_n, .core_int_req, .core_int_ack, .core_int_return,
    .core_save_pc, .core_save_flags, .pmem_rd, .pmem_addr, .pmem_rdata, .core_load_pc,
    .core_handler_addr);
`default_nettype wire

/* bench/viu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic pmem_rd, // Fetch strobe
    input wire logic [15:0] pmem_addr, // Fetch address
    input wire logic core_load_pc, // Handler taken
    output logic core_int_ack, // Instruction boundary
    output logic core_int_return, // Handler finished
    output logic [7:0] pmem_rdata // Vector byte
);
// ----------------------------------------
// Core and vector table
// ----------------------------------------
logic [3:0] ret_r;
assign core_int_return = ret_r[3];
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        core_int_ack <= 1'b0;
        ret_r <= 4'h0;
        pmem_rdata <= 8'h00;
    end else begin
        // Boundary every other cycle: grants meet a ready and a busy core
        core_int_ack <= ~core_int_ack;
        ret_r <= {ret_r[2:0], core_load_pc};
        // Outside the read slot the bus shows junk, never the last byte
        pmem_rdata <= pmem_rd ? 8'h40 + pmem_addr[7:0] : ~pmem_rdata;
    end
end
endmodule : viu_core_model
`default_nettype wire

/* bench/viu_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module viu_top_tb import viu_pkg::*;;
logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, r;
logic port3_bit1_pin = 1, port3_bit2_pin = 1, port3_bit3_pin = 1, timer_input_pin = 1;
logic first_comparator_out = 1, second_comparator_out = 1, low_voltage_detector = 0;
logic wide_timer_event = 0, narrow_timer_timeout = 0, narrow_timer_capture = 0;
logic pready, pslverr, core_int_req, core_int_ack, core_int_return, core_save_pc, irq;
logic core_save_flags, pmem_rd, core_load_pc;
logic [15:0] pmem_addr, core_handler_addr;
logic [7:0] pmem_rdata;
logic [32:0] qe[$], qm[$];
logic [15:0] qv[$];
int num_errors = 0, num_checks = 0, p, s;
always #2.5 sys_clk = ~sys_clk;
viu_top i_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port3_bit1_pin, .port3_bit2_pin, .port3_bit3_pin, .timer_input_pin,
    .first_comparator_out, .second_comparator_out, .wide_timer_event, .narrow_timer_timeout,
    .narrow_timer_capture, .low_voltage_detector, .core_int_req, .core_int_ack, .core_int_return,
    .core_save_pc, .core_save_flags, .pmem_rd, .pmem_addr, .pmem_rdata, .core_load_pc,
    .core_handler_addr, .irq);
viu_core_model i_core (.sys_clk, .rst_n, .pmem_rd, .pmem_addr, .core_load_pc, .core_int_ack,
    .core_int_return, .pmem_rdata);
// ----------------------------------------
// Bus tasks and comparisons
// ----------------------------------------
task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
endtask : apb
task automatic rd(input logic [9:0] idx, input logic [32:0] e, input logic [31:0] m);
    qe.push_back(e);
    qm.push_back({1'b1, m});
    apb(1'b0, idx, 32'h0);
endtask : rd
task automatic chk_rd(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
        num_errors++;
        $display("Error %0t read %h expected %h", $time, g & m, e & m);
    end
endtask : chk_rd
task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
        num_errors++;
        $display("Error %0t output %h expected %h", $time, g, e);
    end
endtask : chk_out
task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask : summarize
always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
        chk_rd({pslverr, prdata}, qe.pop_front(), qm.pop_front());
    if (core_load_pc === 1'b1) chk_out(core_handler_addr, qv.pop_front());
end
initial begin
    #50us;
    num_errors++;
    summarize();
end
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    void'($urandom(45));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(IDX_REQ_EDGE, 33'h0, 32'hff);
    rd(10'h000, 33'h100000000, 32'hffffffff);
    r = $urandom;
    {low_voltage_detector, second_comparator_out, first_comparator_out, timer_input_pin,
        port3_bit3_pin, port3_bit2_pin, port3_bit1_pin} <= r[6:0];
    repeat (4) @(posedge sys_clk);
    rd(IDX_PIN_LEVEL, {26'h0, r[6:0]}, 32'h7f);
    {low_voltage_detector, second_comparator_out, first_comparator_out, port3_bit3_pin,
        port3_bit2_pin, port3_bit1_pin} <= 6'h1f;
    repeat (4) @(posedge sys_clk);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
        wr_loop: begin
            apb(1'b1, IDX_CONTROL, {31'h0, i[1]});
            apb(1'b1, IDX_REQ_EDGE, {24'h0, i[1:0], 6'h3f});
            for (int lv = 0; lv < 2; lv++) begin
                @(posedge sys_clk);
                if (i[1]) {first_comparator_out, second_comparator_out} <= {2{lv[0]}};
                else {port3_bit1_pin, port3_bit2_pin, port3_bit3_pin} <= {3{lv[0]}};
                repeat (4) @(posedge sys_clk);
                rd(IDX_REQ_EDGE, {25'h0, i[1:0], 3'h0, lv ? i[1] : i != 2, !i[1] && !lv,
                    lv ? i[0] : i != 1}, 32'hff);
                apb(1'b1, IDX_REQ_EDGE, {24'h0, i[1:0], 6'h3f});
            end
        end
    end
    $display("edges done");
    @(posedge sys_clk);
    {narrow_timer_timeout, narrow_timer_capture} <= 2'h3;
    @(posedge sys_clk);
    {narrow_timer_timeout, narrow_timer_capture} <= 2'h0;
    rd(IDX_REQ_EDGE, 33'h0, 32'h10);
    apb(1'b1, IDX_CONTROL, 32'h2);
    apb(1'b1, IDX_REQ_ENABLE, 32'h3f);
    p = $urandom % 6;
    apb(1'b1, IDX_PRIORITY, p);
    {wide_timer_event, narrow_timer_timeout, low_voltage_detector} <= 3'h7;
    @(posedge sys_clk);
    {wide_timer_event, narrow_timer_timeout} <= 2'h0;
    repeat (4) @(posedge sys_clk);
    rd(IDX_REQ_EDGE, 33'h38, 32'h3f);
    for (int k = 0; k < 6; k++) begin
        s = (p + k) % 6;
        if (s >= 3) qv.push_back({8'(8'h40 + 2 * s), 8'(8'h41 + 2 * s)});
    end
    apb(1'b1, IDX_REQ_ENABLE, 32'hbf);
    for (int t = 0; t < 300 && qv.size() > 0; t++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    rd(IDX_REQ_EDGE, 33'h0, 32'h3f);
    rd(IDX_REQ_ENABLE, 33'hbf, 32'hff);
    $display("vectors done");
    apb(1'b1, IDX_EVT_MASK, 32'h1);
    #1 chk_out({15'h0, irq}, 16'h1);
    apb(1'b1, IDX_EVT_STATUS, 32'h3);
    #1 chk_out({15'h0, irq}, 16'h0);
    $display("interrupt done");
    summarize();
end
endmodule : viu_top_tb
`default_nettype wire
